// ---- hdl/smc_core.sv ----
// supervisor memory control: dcbi, segment moves, TLB invalidate and sync
//
// Design decisions made here: register access over APB and the register offsets.
module smc_core
   import smc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // translation and protection unit
   output smc_xlat_req_t xlat_req_o,
   input wire smc_xlat_rsp_t xlat_rsp_i,
   // data cache and system bus
   output logic dc_inval_o,
   output logic [31:0] dc_inval_addr_o,
   output logic bus_inval_o,
   // tlb invalidate
   output logic tlbie_o,
   output logic [SMC_TLB_IDX_W-1:0] tlbie_index_o,
   // external sync pin and interrupt
   input wire logic tlb_sync_hold_in_i,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   smc_state_t state_q, state_d;
   logic [SMC_OPC_W-1:0] opc_q;
   logic [SMC_SRIDX_W-1:0] sridx_q;
   logic [31:0] ea_q, data_q;
   logic [SMC_CTRL_W-1:0] ctrl_q;
   logic [1:0] exc_q;
   logic [SMC_IRQ_W-1:0] sts_q, sts_d, msk_q, sts_set;
   logic sync1_q, sync2_q;
   logic pready_q, pslverr_q, irq_q;
   logic [31:0] prdata_q, rd_mux;
   logic dc_inval_q, bus_inval_q, tlbie_q, xlat_req_q;
   logic [31:0] dc_addr_q;
   logic [SMC_TLB_IDX_W-1:0] tlb_idx_q;
   logic [31:0] mem_rdata;
   logic apb_setup, apb_acc, wr_acc, rd_hit, map_hit;
   logic cmd_start, idle, bcast_en;
   logic [SMC_OPC_W-1:0] new_opc;
   logic [SMC_SRIDX_W-1:0] new_sridx, ind_idx, seg_addr;
   logic seg_we, seg_re, op_done;
   logic xl_fault, xl_block, xl_page, xl_noop;

   // address match helper, used for read and write decode
   function automatic logic reg_at(input logic [7:0] a, input logic [7:0] ofs);
      reg_at = (a == ofs);
   endfunction

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // one wait state: pready raised in first access cycle, taken next
   assign apb_setup = psel_i & penable_i & ~pready_q;
   assign apb_acc = psel_i & penable_i & pready_q;
   assign wr_acc = apb_acc & pwrite_i & ~pslverr_q;
   assign map_hit = reg_at(paddr_i, SMC_CMD_OFS) | reg_at(paddr_i, SMC_EA_OFS)
                  | reg_at(paddr_i, SMC_DATA_OFS) | reg_at(paddr_i, SMC_CTRL_OFS)
                  | reg_at(paddr_i, SMC_STAT_OFS) | reg_at(paddr_i, SMC_IRQ_STS_OFS)
                  | reg_at(paddr_i, SMC_IRQ_MSK_OFS);
   assign rd_hit = map_hit;
   assign idle = (state_q == SMC_ST_IDLE);
   assign bcast_en = ctrl_q[SMC_CTRL_BCAST_BIT];

   // read data selection
   assign rd_mux = reg_at(paddr_i, SMC_CMD_OFS) ?
                      {20'h0_0000, sridx_q, 4'h0, opc_q} :
                   reg_at(paddr_i, SMC_EA_OFS) ? ea_q :
                   reg_at(paddr_i, SMC_DATA_OFS) ? data_q :
                   reg_at(paddr_i, SMC_CTRL_OFS) ? {28'h000_0000, ctrl_q} :
                   reg_at(paddr_i, SMC_STAT_OFS) ?
                      {26'h000_0000, exc_q, 3'h0, ~idle} :
                   reg_at(paddr_i, SMC_IRQ_STS_OFS) ? {29'h000_0000, sts_q} :
                   reg_at(paddr_i, SMC_IRQ_MSK_OFS) ? {29'h000_0000, msk_q} :
                   SMC_ZERO32;

   // apb answer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= SMC_ZERO32;
      end else begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup & ~map_hit;
         prdata_q <= (apb_setup & ~pwrite_i & rd_hit) ? rd_mux : SMC_ZERO32;
      end
   end

   // ---------------------------------------------------------------
   // command launch and operand fields
   // ---------------------------------------------------------------
   // a command write while busy is ignored
   assign cmd_start = wr_acc & reg_at(paddr_i, SMC_CMD_OFS) & idle;
   assign new_opc = pwdata_i[SMC_OPC_LSB +: SMC_OPC_W];
   assign new_sridx = pwdata_i[SMC_SRIDX_LSB +: SMC_SRIDX_W];
   // indirect forms take the register number from the operand top bits
   assign ind_idx = ea_q[SMC_SEG_IND_LSB +: SMC_SRIDX_W];

   // segment register access: immediate or indirect selection
   assign seg_addr = (new_opc == SMC_OP_MTSRIN || new_opc == SMC_OP_MFSRIN)
                   ? ind_idx : new_sridx;
   // translation enable bits are not consulted here
   assign seg_we = cmd_start & (new_opc == SMC_OP_MTSR || new_opc == SMC_OP_MTSRIN);
   assign seg_re = cmd_start & (new_opc == SMC_OP_MFSR || new_opc == SMC_OP_MFSRIN);

   // operand and control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opc_q <= 4'h0;
         sridx_q <= 4'h0;
         ea_q <= SMC_ZERO32;
         ctrl_q <= 4'h0;
         msk_q <= 3'h0;
      end else begin
         if (cmd_start) begin
            opc_q <= new_opc;
            sridx_q <= seg_addr;
         end
         if (wr_acc & reg_at(paddr_i, SMC_EA_OFS) & idle) begin
            ea_q <= pwdata_i;
         end
         if (wr_acc & reg_at(paddr_i, SMC_CTRL_OFS)) begin
            ctrl_q <= pwdata_i[SMC_CTRL_W-1:0];
         end
         if (wr_acc & reg_at(paddr_i, SMC_IRQ_MSK_OFS)) begin
            msk_q <= pwdata_i[SMC_IRQ_W-1:0];
         end
      end
   end

   // segment register storage
   smc_seg_mem u_seg_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(seg_we),
      .waddr_i(seg_addr),
      .wdata_i(data_q),
      .re_i(seg_re),
      .raddr_i(seg_addr),
      .shadow_i(ctrl_q[SMC_CTRL_SHADOW_BIT]),
      .rdata_o(mem_rdata)
   );

   // ---------------------------------------------------------------
   // sync pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= tlb_sync_hold_in_i;
         sync2_q <= sync1_q;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // block fault outranks page fault; direct store turns into a no-op
   assign xl_block = xlat_rsp_i.block_prot_fault;
   assign xl_page = ~xlat_rsp_i.block_prot_fault & xlat_rsp_i.page_prot_fault;
   assign xl_fault = xl_block | xl_page;
   assign xl_noop = xlat_rsp_i.direct_store & ~xl_fault;

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         SMC_ST_IDLE: begin
            if (cmd_start & new_opc == SMC_OP_DCBI) begin
               state_d = SMC_ST_XLAT;
            end else if (cmd_start & seg_re) begin
               state_d = SMC_ST_SRRD;
            end else if (cmd_start & new_opc == SMC_OP_TLBSYNC) begin
               state_d = SMC_ST_SYNC;
            end
         end
         SMC_ST_XLAT: begin
            if (xlat_rsp_i.ack) begin
               state_d = SMC_ST_IDLE;
            end
         end
         SMC_ST_SRRD: begin
            state_d = SMC_ST_IDLE;
         end
         SMC_ST_SYNC: begin
            if (~sync2_q) begin
               state_d = SMC_ST_IDLE;
            end
         end
         default: begin
            state_d = SMC_ST_IDLE;
         end
      endcase
   end

   // an operation ends this cycle
   assign op_done = (cmd_start & (seg_we | new_opc == SMC_OP_TLBIE))
                  | (state_q == SMC_ST_XLAT & xlat_rsp_i.ack)
                  | (state_q == SMC_ST_SRRD)
                  | (state_q == SMC_ST_SYNC & ~sync2_q);

   // events raising sticky interrupt bits
   assign sts_set[SMC_IRQ_DONE_BIT] = op_done;
   assign sts_set[SMC_IRQ_DSI_BIT] = state_q == SMC_ST_XLAT & xlat_rsp_i.ack & xl_fault;
   assign sts_set[SMC_IRQ_PROG_BIT] = cmd_start & new_opc == SMC_OP_TLBIA;
   // write-one-to-clear, a new event wins over the clear
   assign sts_d = (sts_q & ~((wr_acc & reg_at(paddr_i, SMC_IRQ_STS_OFS))
                  ? pwdata_i[SMC_IRQ_W-1:0] : 3'h0)) | sts_set;

   // state, status and data registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= SMC_ST_IDLE;
         sts_q <= 3'h0;
         irq_q <= 1'b0;
         exc_q <= SMC_EXC_NONE;
         data_q <= SMC_ZERO32;
      end else begin
         state_q <= state_d;
         sts_q <= sts_d;
         irq_q <= |(sts_d & msk_q);
         if (cmd_start) begin
            exc_q <= (new_opc == SMC_OP_TLBIA) ? SMC_EXC_PROGRAM : SMC_EXC_NONE;
         end else if (state_q == SMC_ST_XLAT & xlat_rsp_i.ack) begin
            exc_q <= xl_block ? SMC_EXC_DSI_BLOCK :
                     xl_page ? SMC_EXC_DSI_PAGE : SMC_EXC_NONE;
         end
         if (state_q == SMC_ST_SRRD) begin
            data_q <= mem_rdata;
         end else if (wr_acc & reg_at(paddr_i, SMC_DATA_OFS) & idle) begin
            data_q <= pwdata_i;
         end
      end
   end

   // output pulses towards cache, bus, TLBs and MMU
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xlat_req_q <= 1'b0;
         dc_inval_q <= 1'b0;
         bus_inval_q <= 1'b0;
         dc_addr_q <= SMC_ZERO32;
         tlbie_q <= 1'b0;
         tlb_idx_q <= 6'h00;
      end else begin
         // request held until the MMU answers
         xlat_req_q <= state_d == SMC_ST_XLAT;
         // cache acts only after a clean, non direct-store check
         // the cache drops the block from E or M alike, no copy-back,
         // and no disable or lock state gates it
         dc_inval_q <= state_q == SMC_ST_XLAT & xlat_rsp_i.ack & ~xl_fault & ~xl_noop;
         bus_inval_q <= state_q == SMC_ST_XLAT & xlat_rsp_i.ack & ~xl_fault & ~xl_noop & bcast_en;
         if (state_q == SMC_ST_XLAT & xlat_rsp_i.ack) begin
            dc_addr_q <= ea_q;
         end
         // both ways of both TLBs at the EA index, whatever the enables
         tlbie_q <= cmd_start & new_opc == SMC_OP_TLBIE;
         if (cmd_start & new_opc == SMC_OP_TLBIE) begin
            tlb_idx_q <= ea_q[SMC_TLB_IDX_LSB +: SMC_TLB_IDX_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign xlat_req_o = '{req: xlat_req_q, is_store: 1'b1, ea: ea_q};
   assign dc_inval_o = dc_inval_q;
   assign dc_inval_addr_o = dc_addr_q;
   assign bus_inval_o = bus_inval_q;
   assign tlbie_o = tlbie_q;
   assign tlbie_index_o = tlb_idx_q;
   assign irq_o = irq_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   bcast_needs_abe_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         dc_inval_o |-> (bus_inval_o == $past(bcast_en)))
      else $error("broadcast does not follow the enable bit");
   inval_after_xlat_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         dc_inval_o |-> $past(state_q == SMC_ST_XLAT && xlat_rsp_i.ack))
      else $error("cache invalidate without completed translation");
   store_like_xlat_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         xlat_req_o.req |-> xlat_req_o.is_store && state_q == SMC_ST_XLAT)
      else $error("dcbi translation not issued as a store");
   block_fault_first_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state_q == SMC_ST_XLAT && xlat_rsp_i.ack && xlat_rsp_i.block_prot_fault)
         |=> (exc_q == SMC_EXC_DSI_BLOCK) && sts_q[SMC_IRQ_DSI_BIT] && !dc_inval_o)
      else $error("block protection fault not taken first");
   direct_store_noop_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state_q == SMC_ST_XLAT && xlat_rsp_i.ack && xlat_rsp_i.direct_store)
         |=> !dc_inval_o && !bus_inval_o)
      else $error("direct-store dcbi touched cache or bus");
   tlbie_index_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (cmd_start && new_opc == SMC_OP_TLBIE)
         |=> tlbie_o && tlbie_index_o == $past(ea_q[SMC_TLB_IDX_LSB +: SMC_TLB_IDX_W]) ##1 !tlbie_o)
      else $error("tlbie pulse or index wrong");
   sync_stall_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state_q == SMC_ST_SYNC && sync2_q) |=> state_q == SMC_ST_SYNC)
      else $error("tlbsync finished while sync hold active");
   sync_release_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (state_q == SMC_ST_SYNC && !sync2_q) |=> idle && sts_q[SMC_IRQ_DONE_BIT])
      else $error("tlbsync did not end when sync hold fell");
   tlbia_program_a:
      assert property (@(posedge clk_i) disable iff (rst_i)
         (cmd_start && new_opc == SMC_OP_TLBIA)
         |=> sts_q[SMC_IRQ_PROG_BIT] && exc_q == SMC_EXC_PROGRAM && idle && !tlbie_o)
      else $error("tlbia did not raise a program exception");
endmodule

// ---- hdl/smc_pkg.sv ----
// constants, types and field layout of the supervisor memory control block
// Behaviour
// - dcbi translates and checks EA before cache action
// - dcbi hit invalidates block, modified data dropped
// - dcbi broadcast only when broadcast enable set
// - dcbi translated and checked like a store
// - dcbi acts even with cache disabled/locked
// - block translation fault outranks page fault
// - direct-store segment dcbi is a no-op
// - segment moves ignore translation enable bits
// - segment moves: immediate and indirect forms
// - shadow select reads instruction-side shadow copy
// - tlbie clears both ways, both TLBs, EA[14:19]
// - tlbie runs regardless of translation enables
// - tlbsync stalls until sync hold input inactive
// - tlbia raises illegal-instruction program exception
package smc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] SMC_CMD_OFS = 8'h00;
   localparam logic [7:0] SMC_EA_OFS = 8'h04;
   localparam logic [7:0] SMC_DATA_OFS = 8'h08;
   localparam logic [7:0] SMC_CTRL_OFS = 8'h0C;
   localparam logic [7:0] SMC_STAT_OFS = 8'h10;
   localparam logic [7:0] SMC_IRQ_STS_OFS = 8'h14;
   localparam logic [7:0] SMC_IRQ_MSK_OFS = 8'h18;
   // ---------------------------------------------------------------
   // command register fields and opcodes
   // ---------------------------------------------------------------
   localparam int SMC_OPC_LSB = 0;
   localparam int SMC_OPC_W = 4;
   localparam int SMC_SRIDX_LSB = 8;
   localparam int SMC_SRIDX_W = 4;
   localparam logic [3:0] SMC_OP_DCBI = 4'h1;
   localparam logic [3:0] SMC_OP_MTSR = 4'h2;
   localparam logic [3:0] SMC_OP_MTSRIN = 4'h3;
   localparam logic [3:0] SMC_OP_MFSR = 4'h4;
   localparam logic [3:0] SMC_OP_MFSRIN = 4'h5;
   localparam logic [3:0] SMC_OP_TLBIE = 4'h6;
   localparam logic [3:0] SMC_OP_TLBSYNC = 4'h7;
   localparam logic [3:0] SMC_OP_TLBIA = 4'h8;
   // ---------------------------------------------------------------
   // control register bits (machine state bits have no effect here)
   // ---------------------------------------------------------------
   localparam int SMC_CTRL_BCAST_BIT = 0;
   localparam int SMC_CTRL_SHADOW_BIT = 1;
   localparam int SMC_CTRL_IXLAT_BIT = 2;
   localparam int SMC_CTRL_DXLAT_BIT = 3;
   localparam int SMC_CTRL_W = 4;
   // ---------------------------------------------------------------
   // status register: busy, last exception code
   // ---------------------------------------------------------------
   localparam int SMC_STAT_BUSY_BIT = 0;
   localparam int SMC_STAT_EXC_LSB = 4;
   localparam logic [1:0] SMC_EXC_NONE = 2'h0;
   localparam logic [1:0] SMC_EXC_DSI_BLOCK = 2'h1;
   localparam logic [1:0] SMC_EXC_DSI_PAGE = 2'h2;
   localparam logic [1:0] SMC_EXC_PROGRAM = 2'h3;
   // ---------------------------------------------------------------
   // interrupt status and mask bits
   // ---------------------------------------------------------------
   localparam int SMC_IRQ_W = 3;
   localparam int SMC_IRQ_DONE_BIT = 0;
   localparam int SMC_IRQ_DSI_BIT = 1;
   localparam int SMC_IRQ_PROG_BIT = 2;
   // ---------------------------------------------------------------
   // address fields
   // ---------------------------------------------------------------
   localparam int SMC_TLB_IDX_LSB = 12; // EA bits 14..19, msb-0 numbering
   localparam int SMC_TLB_IDX_W = 6;
   localparam int SMC_SEG_IND_LSB = 28; // operand bits 0..3, msb-0 numbering
   localparam logic [31:0] SMC_ZERO32 = 32'h0000_0000;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SMC_ST_IDLE,
      SMC_ST_XLAT,
      SMC_ST_SRRD,
      SMC_ST_SYNC
   } smc_state_t;
   // answer of the translation and protection unit
   typedef struct packed {
      logic ack;
      logic block_prot_fault;
      logic page_prot_fault;
      logic direct_store;
   } smc_xlat_rsp_t;
   // translation request towards the MMU
   typedef struct packed {
      logic req;
      logic is_store;
      logic [31:0] ea;
   } smc_xlat_req_t;
endpackage

// ---- hdl/smc_seg_mem.sv ----
// segment register file with instruction-side shadow copy
module smc_seg_mem
   import smc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write port
   input wire logic we_i,
   input wire logic [SMC_SRIDX_W-1:0] waddr_i,
   input wire logic [31:0] wdata_i,
   // read port
   input wire logic re_i,
   input wire logic [SMC_SRIDX_W-1:0] raddr_i,
   input wire logic shadow_i,
   output logic [31:0] rdata_o
);
   logic [31:0] prim_mem [16];
   logic [31:0] shad_mem [16];
   logic [31:0] rd_sel;

   // writes update the primary and the shadow copy together
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         prim_mem[waddr_i] <= wdata_i;
         shad_mem[waddr_i] <= wdata_i;
      end
   end

   // shadow select picks the instruction-side copy
   assign rd_sel = shadow_i ? shad_mem[raddr_i] : prim_mem[raddr_i];

   // registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= SMC_ZERO32;
      end else if (re_i) begin
         rdata_o <= rd_sel;
      end
   end
endmodule

// ---- test/smc_far_model.sv ----
// translation unit and sync-pin source at the far side of the block
module smc_far_model
   import smc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // translation request and scripted answer
   input wire smc_xlat_req_t xlat_req_i,
   input wire logic [2:0] fault_i,
   input wire logic [3:0] lat_i,
   output smc_xlat_rsp_t xlat_rsp_o,
   // pending remote invalidations
   input wire logic sync_go_i,
   output logic sync_hold_o
);
   logic [3:0] wait_q;
   logic [3:0] sync_q;
   logic ack_q;
   logic tog_q;
   // fault lines carry no meaning outside the ack cycle, so they toggle there
   assign xlat_rsp_o = ack_q ? {1'b1, fault_i} : {1'b0, {3{tog_q}}};
   // pin held while remote invalidations are outstanding
   assign sync_hold_o = (sync_q != 4'h0);
   // answer lat_i+1 cycles after the request rises; pending count reloads on sync_go_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_q <= 4'h0;
         sync_q <= 4'h0;
         ack_q <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= ~tog_q;
         ack_q <= 1'b0;
         if (xlat_req_i.req && !ack_q) begin
            wait_q <= (wait_q == lat_i) ? 4'h0 : wait_q + 4'h1;
            ack_q <= (wait_q == lat_i);
         end
         if (sync_go_i) begin
            sync_q <= 4'hF;
         end else if (sync_q != 4'h0) begin
            sync_q <= sync_q - 4'h1;
         end
      end
   end
endmodule

// ---- test/supervisor_memory_control_ops_tb.sv ----
// self-checking bench of the supervisor memory control block
module supervisor_memory_control_ops_tb
   import smc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // dcbi cases: broadcast enable, block/page/direct-store fault, dc pulse, bus pulse, exception
   localparam logic [7:0] DTAB [5] = '{8'h8C, 8'h08, 8'h90, 8'hA2, 8'hE1};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sync_go = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat, dc_addr, ea_seen;
   logic pready, pslverr, rerr, dc_inval, bus_inval, tlbie, sync_hold, irq, st_seen;
   logic [5:0] tlbidx;
   logic [2:0] fault = 3'h0;
   logic [3:0] lat = 4'h0;
   smc_xlat_req_t xreq;
   smc_xlat_rsp_t xrsp;
   int n_fail = 0, checks = 0, cyc = 0, n_dc = 0, n_bus = 0, n_tlb = 0;
   smc_core smc_core_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .xlat_req_o(xreq), .xlat_rsp_i(xrsp), .dc_inval_o(dc_inval), .dc_inval_addr_o(dc_addr),
      .bus_inval_o(bus_inval), .tlbie_o(tlbie), .tlbie_index_o(tlbidx), .tlb_sync_hold_in_i(sync_hold),
      .irq_o(irq));
   smc_far_model smc_far_model_i (.clk_i(clk_i), .rst_i(rst_i), .xlat_req_i(xreq), .fault_i(fault),
      .lat_i(lat), .xlat_rsp_o(xrsp), .sync_go_i(sync_go), .sync_hold_o(sync_hold));
   // 100 ns clock
   always #50 clk_i = ~clk_i;
   // pulse counters, translation capture and run limit
   always @(posedge clk_i) begin
      cyc++;
      if (dc_inval === 1'b1) n_dc++;
      if (bus_inval === 1'b1) n_bus++;
      if (tlbie === 1'b1) n_tlb++;
      if (xreq.req === 1'b1 && xrsp.ack === 1'b1) begin
         ea_seen = xreq.ea;
         st_seen = xreq.is_store;
      end
      if (cyc == 30000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // issue a command and poll busy; rdat ends as the final status
   task automatic cmd(input logic [3:0] op, input logic [3:0] idx);
      apb(1'b1, SMC_CMD_OFS, {20'h0, idx, 4'h0, op});
      do apb(1'b0, SMC_STAT_OFS, 32'h0); while (rdat[0] === 1'b1);
   endtask
   task automatic t_regs();
      apb(1'b0, SMC_STAT_OFS, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, SMC_CTRL_OFS, 32'h0000_000C);
      apb(1'b0, SMC_CTRL_OFS, 32'h0);
      chk(rdat, 32'h0000_000C);
   endtask
   task automatic t_seg();
      apb(1'b1, SMC_DATA_OFS, 32'h1234_5678);
      cmd(SMC_OP_MTSR, 4'h5);
      apb(1'b1, SMC_DATA_OFS, 32'h0ABC_DEF0);
      apb(1'b1, SMC_EA_OFS, 32'hA000_0000);
      cmd(SMC_OP_MTSRIN, 4'h0);
      apb(1'b1, SMC_EA_OFS, 32'h5FFF_FFFF);
      cmd(SMC_OP_MFSRIN, 4'hA);
      apb(1'b0, SMC_DATA_OFS, 32'h0);
      chk(rdat, 32'h1234_5678);
      apb(1'b1, SMC_CTRL_OFS, 32'h0000_0002);
      cmd(SMC_OP_MFSR, 4'hA);
      apb(1'b0, SMC_DATA_OFS, 32'h0);
      chk(rdat, 32'h0ABC_DEF0);
      apb(1'b1, SMC_CTRL_OFS, 32'h0);
      cmd(SMC_OP_MFSR, 4'h5);
      apb(1'b0, SMC_DATA_OFS, 32'h0);
      chk(rdat, 32'h1234_5678);
   endtask
   task automatic t_dcbi();
      int dc0, bus0;
      logic [7:0] t;
      logic [31:0] ea;
      for (int i = 0; i < 5; i++) begin
         t = DTAB[i];
         ea = 32'h8765_4320 + 32'(i * 64);
         dc0 = n_dc;
         bus0 = n_bus;
         fault <= t[6:4];
         lat <= 4'(i);
         apb(1'b1, SMC_CTRL_OFS, {31'h0, t[7]});
         apb(1'b1, SMC_EA_OFS, ea);
         cmd(SMC_OP_DCBI, 4'h0);
         chk(ea_seen, ea);
         chk({31'h0, st_seen}, 32'h1);
         chk(32'(n_dc - dc0), {31'h0, t[3]});
         chk(32'(n_bus - bus0), {31'h0, t[2]});
         chk({30'h0, rdat[5:4]}, {30'h0, t[1:0]});
         if (t[3]) chk(dc_addr, ea);
      end
      fault <= 3'h0;
   endtask
   task automatic t_tlb();
      int t0;
      apb(1'b1, SMC_CTRL_OFS, 32'h0000_000C);
      for (int k = 0; k < 64; k++) begin
         t0 = n_tlb;
         apb(1'b1, SMC_EA_OFS, 32'hA5A0_0A5A | (32'(k) << 12));
         cmd(SMC_OP_TLBIE, 4'h0);
         chk(32'(n_tlb - t0), 32'h1);
         chk({26'h0, tlbidx}, 32'(k));
      end
      sync_go <= 1'b1;
      apb(1'b1, SMC_CMD_OFS, {28'h0, SMC_OP_TLBSYNC});
      sync_go <= 1'b0;
      apb(1'b0, SMC_STAT_OFS, 32'h0);
      chk({31'h0, rdat[0]}, 32'h1);
      do apb(1'b0, SMC_STAT_OFS, 32'h0); while (rdat[0] === 1'b1);
      chk({31'h0, sync_hold}, 32'h0);
   endtask
   task automatic t_irq();
      int t0;
      t0 = n_tlb;
      apb(1'b0, SMC_IRQ_STS_OFS, 32'h0);
      chk({31'h0, rdat[SMC_IRQ_DSI_BIT]}, 32'h1);
      apb(1'b1, SMC_IRQ_STS_OFS, 32'h0000_0007);
      apb(1'b1, SMC_IRQ_MSK_OFS, 32'h0000_0004);
      cmd(SMC_OP_TLBIA, 4'h0);
      chk({30'h0, rdat[5:4]}, {30'h0, SMC_EXC_PROGRAM});
      chk(32'(n_tlb - t0), 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, SMC_IRQ_MSK_OFS, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, SMC_IRQ_MSK_OFS, 32'h0000_0004);
      apb(1'b1, SMC_IRQ_STS_OFS, 32'h0000_0004);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, SMC_IRQ_STS_OFS, 32'h0);
      chk({31'h0, rdat[SMC_IRQ_PROG_BIT]}, 32'h0);
   endtask
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_seg();
      t_dcbi();
      t_tlb();
      t_irq();
      test_done();
   end
endmodule
